// ---- inc/gcs_pkg.sv ----
`default_nettype none
package gcs_pkg;
   // data area layout
   localparam logic [9:0]  STATUS_ADDR_HI   = 10'h000;
   localparam logic [9:0]  STATUS_ADDR_LO   = 10'h001;
   localparam logic [9:0]  CONTROL_ADDR_HI  = 10'h200;
   localparam logic [9:0]  CONTROL_ADDR_LO  = 10'h201;
   // status word fields
   localparam int          SW_SEND_BIT      = 15;
   localparam int          SW_ACK_BIT       = 14;
   localparam int          SW_VALID_BIT     = 13;
   localparam int          SW_CODE_HI       = 12;
   localparam int          SW_CODE_LO       = 8;
   // control word fields
   localparam int          CW_ACK_BIT       = 15;
   localparam int          CW_SEND_BIT      = 14;
   localparam int          CW_VALID_BIT     = 13;
   localparam logic [15:0] WORD_RESET       = 16'h0000;
   // enable options
   localparam logic [1:0]  CSW_DISABLED     = 2'h0;
   localparam logic [1:0]  CSW_ENABLED      = 2'h1;
   localparam logic [1:0]  CSW_NO_LOCK      = 2'h2;
   // status codes, master modes
   localparam logic [4:0]  MC_RETRANS       = 5'h00;
   localparam logic [4:0]  MC_ONE_MISSING   = 5'h01;
   localparam logic [4:0]  MC_MANY_MISSING  = 5'h02;
   localparam logic [4:0]  MC_OVERRUN       = 5'h03;
   localparam logic [4:0]  MC_OTHER         = 5'h04;
   // status codes, generic mode
   localparam logic [4:0]  GC_INVALID_TRANS = 5'h00;
   localparam logic [4:0]  GC_FRAME_ERR     = 5'h01;
   localparam logic [4:0]  GC_OFFLINE_TMO   = 5'h02;
   localparam logic [4:0]  GC_OVERRUN       = 5'h03;
   localparam logic [4:0]  GC_OTHER         = 5'h04;
   localparam logic [4:0]  CODE_NO_ERROR    = 5'h1F;
   localparam logic [7:0]  ARG_NONE         = 8'h00;
   // event indices: 0 retrans/invalid, 1 one missing/frame, 2 many/offline tmo,
   // 3 overrun, 4 other
   localparam int          NUM_EVT          = 5;
   typedef enum logic [2:0] {
      GCS_OFFLINE  = 3'b001,
      GCS_WAIT_DV  = 3'b010,
      GCS_EXCHANGE = 3'b100
   } gcs_state_e;
endpackage
`default_nettype wire

// ---- hdl/gcs_words.sv ----
// Function
// - words inactive until configuration enables them
// - status at 0x000, control at 0x200
// - both words stored most significant byte first
// - startup lock waits for control data-valid
// - no lock: exchange starts when online
// - status data-valid cleared once set only by generic mode, disable or reset
// - status bit15 send, bit14 confirm
// - master mode bit13 sticky all-done flag
// - generic mode leaves status valid unused
// - code bits 12..8, argument bits 7..0
// - master 0x00 retransmission warning with counter
// - master 0x01/0x02 missing node errors
// - master 0x03 overrun, 0x04 other error
// - resolved errors followed by code 0x1F
// - generic 0x00 invalid transaction counter error
// - generic 0x01 frame error warning
// - generic 0x02 offline timeout counter error
// - generic 0x03 overrun, 0x04 other
// - control bit13 gates sub-network exchange with startup lock only
`timescale 1ns/1ps
`default_nettype none
module gcs_words (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] csw_mode,
   input  wire logic       generic_mode,
   input  wire logic       fieldbus_online,
   // byte access to data areas
   input  wire logic [9:0] area_addr,
   input  wire logic       area_wr,
   input  wire logic [7:0] area_wdata,
   input  wire logic       area_rd,
   output logic      [7:0] area_rdata,
   output logic            area_hit,
   // sub-network side
   input  wire logic       all_trans_done,
   input  wire logic [4:0] evt_strobe,
   input  wire logic [7:0] evt_arg,
   input  wire logic       errors_cleared,
   input  wire logic       report_req,
   output logic            report_busy,
   output logic            exchange_en,
   output logic            ctrl_valid,
   output logic            ctrl_report_new,
   output logic      [7:0] ctrl_data,
   output logic      [15:0] status_word,
   output logic      [15:0] control_word
);
   logic [15:0]          status_r, status_nxt;
   logic [15:0]          control_r, control_nxt;
   logic [7:0]           rdata_r, rdata_nxt;
   logic                 hit_r, hit_nxt;
   logic                 err_pend_r, err_pend_nxt;
   logic                 pend_r, pend_nxt;
   logic [4:0]           pcode_r, pcode_nxt;
   logic [7:0]           parg_r, parg_nxt;
   logic                 ctl_seen_r, ctl_seen_nxt;
   logic                 cnew_r, cnew_nxt;
   localparam int        NE = gcs_pkg::NUM_EVT;
   // one-hot byte lanes of the two words
   localparam logic [3:0] LANE_NONE  = 4'h0;
   localparam logic [3:0] LANE_ST_HI = 4'h1;
   localparam logic [3:0] LANE_ST_LO = 4'h2;
   localparam logic [3:0] LANE_CT_HI = 4'h4;
   localparam logic [3:0] LANE_CT_LO = 4'h8;

   logic                 exch_r, exch_nxt;
   logic                 valid_r, valid_nxt;
   gcs_pkg::gcs_state_e  state_r, state_nxt;
   logic                 enabled;
   logic [3:0]           lane;
   logic [NE-1:0]        is_err;

   // error-type events differ by mode
   function automatic logic evt_is_error(input logic gen, input int idx);
      if (idx == 0) begin
         return gen;
      end
      if (idx == 1) begin
         return !gen;
      end
      return (idx != 3);
   endfunction

   // generic frame error, overrun and other reports carry no argument
   function automatic logic evt_has_arg(input logic gen, input int idx);
      if (!gen) begin
         return 1'b1;
      end
      return (idx == 0) || (idx == 2);
   endfunction

   // data area byte lane, even address holds the high byte
   function automatic logic [3:0] area_lane(input logic [9:0] addr);
      logic [3:0] l;
      l = LANE_NONE;
      unique case (addr)
         gcs_pkg::STATUS_ADDR_HI:  l = LANE_ST_HI;
         gcs_pkg::STATUS_ADDR_LO:  l = LANE_ST_LO;
         gcs_pkg::CONTROL_ADDR_HI: l = LANE_CT_HI;
         gcs_pkg::CONTROL_ADDR_LO: l = LANE_CT_LO;
         default:                  l = LANE_NONE;
      endcase
      return l;
   endfunction

   function automatic logic [4:0] evt_code(input logic gen, input int idx);
      logic [4:0] c;
      c = gen ? gcs_pkg::GC_OTHER : gcs_pkg::MC_OTHER;
      case (idx)
         0: c = gen ? gcs_pkg::GC_INVALID_TRANS : gcs_pkg::MC_RETRANS;
         1: c = gen ? gcs_pkg::GC_FRAME_ERR : gcs_pkg::MC_ONE_MISSING;
         2: c = gen ? gcs_pkg::GC_OFFLINE_TMO : gcs_pkg::MC_MANY_MISSING;
         3: c = gen ? gcs_pkg::GC_OVERRUN : gcs_pkg::MC_OVERRUN;
         default: c = gen ? gcs_pkg::GC_OTHER : gcs_pkg::MC_OTHER;
      endcase
      return c;
   endfunction

   genvar g;
   generate
      for (g = 0; g < NE; g = g + 1) begin : g_err
         assign is_err[g] = evt_is_error(generic_mode, g);
      end
   endgenerate

   assign enabled = (csw_mode != gcs_pkg::CSW_DISABLED);
   assign lane    = area_lane(area_addr);

   // report selection and status word
   always_comb begin
      logic       found;
      logic [4:0] c;
      logic [7:0] a;
      logic       e;
      found        = 1'b0;
      c            = pcode_r;
      a            = parg_r;
      e            = 1'b0;
      status_nxt   = status_r;
      pend_nxt     = pend_r;
      pcode_nxt    = pcode_r;
      parg_nxt     = parg_r;
      err_pend_nxt = err_pend_r;
      for (int i = 0; i < NE; i++) begin
         if (evt_strobe[i] && !found) begin
            found = 1'b1;
            c     = evt_code(generic_mode, i);
            e     = is_err[i];
            a     = evt_has_arg(generic_mode, i) ? evt_arg : gcs_pkg::ARG_NONE;
         end
      end
      if (found) begin
         pend_nxt  = 1'b1;
         pcode_nxt = c;
         parg_nxt  = a;
         if (e) begin
            err_pend_nxt = 1'b1;
         end
      end else if (report_req && err_pend_r && errors_cleared) begin
         pend_nxt     = 1'b1;
         pcode_nxt    = gcs_pkg::CODE_NO_ERROR;
         parg_nxt     = gcs_pkg::ARG_NONE;
         err_pend_nxt = 1'b0;
      end
      // post a report when the controller has confirmed the last one
      if (pend_r && (status_r[gcs_pkg::SW_SEND_BIT] == control_r[gcs_pkg::CW_ACK_BIT])) begin
         status_nxt[gcs_pkg::SW_CODE_HI:gcs_pkg::SW_CODE_LO] = pcode_r;
         status_nxt[7:0] = parg_r;
         status_nxt[gcs_pkg::SW_SEND_BIT] = ~status_r[gcs_pkg::SW_SEND_BIT];
         if (!found) begin
            pend_nxt = 1'b0;
         end
      end
      // echo the controller's send flag as acknowledge
      status_nxt[gcs_pkg::SW_ACK_BIT] = control_r[gcs_pkg::CW_SEND_BIT];
      status_nxt[gcs_pkg::SW_VALID_BIT] = valid_nxt;
   end

   // fieldbus data area access, big-endian bytes
   always_comb begin
      control_nxt  = control_r;
      rdata_nxt    = rdata_r;
      hit_nxt      = 1'b0;
      ctl_seen_nxt = ctl_seen_r;
      cnew_nxt     = 1'b0;
      if (enabled && area_wr) begin
         if (lane == LANE_CT_HI) begin
            control_nxt[15:8] = area_wdata;
            hit_nxt           = 1'b1;
         end else if (lane == LANE_CT_LO) begin
            control_nxt[7:0] = area_wdata;
            hit_nxt          = 1'b1;
         end
      end
      if (enabled && area_rd) begin
         unique case (lane)
            LANE_ST_HI: begin
               rdata_nxt = status_r[15:8];
               hit_nxt   = 1'b1;
            end
            LANE_ST_LO: begin
               rdata_nxt = status_r[7:0];
               hit_nxt   = 1'b1;
            end
            LANE_CT_HI: begin
               rdata_nxt = control_r[15:8];
               hit_nxt   = 1'b1;
            end
            LANE_CT_LO: begin
               rdata_nxt = control_r[7:0];
               hit_nxt   = 1'b1;
            end
            default: rdata_nxt = 8'h00;
         endcase
      end
      // controller's new report: its send flag changed
      if (control_r[gcs_pkg::CW_SEND_BIT] != ctl_seen_r) begin
         ctl_seen_nxt = control_r[gcs_pkg::CW_SEND_BIT];
         cnew_nxt     = 1'b1;
      end
   end

   // data consistency state machine
   always_comb begin
      state_nxt = state_r;
      exch_nxt  = 1'b0;
      unique case (state_r)
         gcs_pkg::GCS_OFFLINE: begin
            if (fieldbus_online) begin
               state_nxt = gcs_pkg::GCS_WAIT_DV;
            end
         end
         gcs_pkg::GCS_WAIT_DV: begin
            if (!fieldbus_online) begin
               state_nxt = gcs_pkg::GCS_OFFLINE;
            end else if (csw_mode != gcs_pkg::CSW_ENABLED) begin
               state_nxt = gcs_pkg::GCS_EXCHANGE;
            end else if (control_r[gcs_pkg::CW_VALID_BIT]) begin
               state_nxt = gcs_pkg::GCS_EXCHANGE;
            end
         end
         gcs_pkg::GCS_EXCHANGE: begin
            if (!fieldbus_online) begin
               state_nxt = gcs_pkg::GCS_OFFLINE;
            end
         end
         default: state_nxt = gcs_pkg::GCS_OFFLINE;
      endcase
      if (state_nxt == gcs_pkg::GCS_EXCHANGE) begin
         // without the start-up lock exchange runs as soon as the state allows
         exch_nxt = 1'b1;
         if (enabled && csw_mode == gcs_pkg::CSW_ENABLED) begin
            exch_nxt = control_nxt[gcs_pkg::CW_VALID_BIT];
         end
      end
   end

   // report and status registers
   always_ff @(posedge clk) begin
      if (rst) begin
         status_r   <= gcs_pkg::WORD_RESET;
         err_pend_r <= 1'b0;
         pend_r     <= 1'b0;
         pcode_r    <= gcs_pkg::CODE_NO_ERROR;
         parg_r     <= gcs_pkg::ARG_NONE;
      end else begin
         status_r   <= enabled ? status_nxt : gcs_pkg::WORD_RESET;
         err_pend_r <= err_pend_nxt;
         pend_r     <= pend_nxt;
         pcode_r    <= pcode_nxt;
         parg_r     <= parg_nxt;
      end
   end

   // control word and data area port registers
   always_ff @(posedge clk) begin
      if (rst) begin
         control_r  <= gcs_pkg::WORD_RESET;
         rdata_r    <= 8'h00;
         hit_r      <= 1'b0;
         ctl_seen_r <= 1'b0;
         cnew_r     <= 1'b0;
      end else begin
         control_r  <= enabled ? control_nxt : gcs_pkg::WORD_RESET;
         rdata_r    <= rdata_nxt;
         hit_r      <= hit_nxt;
         ctl_seen_r <= ctl_seen_nxt;
         cnew_r     <= cnew_nxt;
      end
   end

   // consistency state registers
   always_ff @(posedge clk) begin
      if (rst) begin
         exch_r     <= 1'b0;
         state_r    <= gcs_pkg::GCS_OFFLINE;
      end else begin
         exch_r     <= exch_nxt;
         state_r    <= state_nxt;
      end
   end

   // status data-valid: set once in master mode, cleared by generic mode, disable or reset
   always_comb begin
      valid_nxt = valid_r;
      if (generic_mode) begin
         valid_nxt = 1'b0;
      end else if (all_trans_done && exch_r) begin
         valid_nxt = 1'b1;
      end
   end

   // sticky data-valid register
   always_ff @(posedge clk) begin
      if (rst) begin
         valid_r <= 1'b0;
      end else begin
         valid_r <= enabled ? valid_nxt : 1'b0;
      end
   end

   assign area_rdata      = rdata_r;
   assign area_hit        = hit_r;
   assign report_busy     = pend_r;
   assign exchange_en     = exch_r;
   assign ctrl_valid      = control_r[gcs_pkg::CW_VALID_BIT];
   assign ctrl_report_new = cnew_r;
   assign ctrl_data       = control_r[7:0];
   assign status_word     = status_r;
   assign control_word    = control_r;
endmodule // gcs_words
`default_nettype wire

// ---- testbench/gcs_words_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcs_chk (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [1:0]  csw_mode,
   input  wire logic        generic_mode,
   input  wire logic        fieldbus_online,
   input  wire logic [9:0]  area_addr,
   input  wire logic        area_wr,
   input  wire logic [7:0]  area_wdata,
   input  wire logic        area_rd,
   input  wire logic [7:0]  area_rdata,
   input  wire logic        area_hit,
   input  wire logic        all_trans_done,
   input  wire logic        exchange_en,
   input  wire logic [15:0] status_word,
   input  wire logic [15:0] control_word
);
   logic on;
   assign on = csw_mode != 2'h0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_off;
      !on && !$past(on) |-> status_word == 16'h0000 && control_word == 16'h0000;
   endproperty
   a_off: assert property (p_off) else $error("words not zero while disabled");
   property p_rd_hi;
      area_rd && on && area_addr == 10'h000 |=> area_hit && area_rdata == $past(status_word[15:8]);
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("status high byte read wrong");
   property p_rd_lo;
      area_rd && on && area_addr == 10'h001 |=> area_rdata == $past(status_word[7:0]);
   endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("status low byte read wrong");
   property p_wr_hi;
      area_wr && on && area_addr == 10'h200 |=> control_word[15:8] == $past(area_wdata);
   endproperty
   a_wr_hi: assert property (p_wr_hi) else $error("control high byte write lost");
   property p_sticky;
      $past(status_word[13]) && $past(on) && !$past(rst) |-> status_word[13];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status valid cleared");
   property p_set13;
      $rose(status_word[13]) |-> !$past(generic_mode) && $past(all_trans_done);
   endproperty
   a_set13: assert property (p_set13) else $error("status valid set without cause");
   property p_ack;
      $past(on) && !$past(rst) |-> status_word[14] == $past(control_word[14]);
   endproperty
   a_ack: assert property (p_ack) else $error("confirm flag not mirrored");
   property p_lock;
      (csw_mode == 2'h1 && !control_word[13]) [*3] |-> !exchange_en;
   endproperty
   a_lock: assert property (p_lock) else $error("exchange without data valid");
   property p_nolock;
      (csw_mode == 2'h2 && fieldbus_online) [*4] |-> exchange_en;
   endproperty
   a_nolock: assert property (p_nolock) else $error("no exchange when online");
   c_lock: cover property (exchange_en && csw_mode == 2'h1);
   c_valid: cover property (status_word[13]);
   c_tog: cover property ($rose(status_word[15]));
endmodule // gcs_chk
bind gcs_words gcs_chk u_chk (.clk(clk), .rst(rst), .csw_mode(csw_mode),
   .generic_mode(generic_mode), .fieldbus_online(fieldbus_online), .area_addr(area_addr),
   .area_wr(area_wr), .area_wdata(area_wdata), .area_rd(area_rd), .area_rdata(area_rdata),
   .area_hit(area_hit), .all_trans_done(all_trans_done), .exchange_en(exchange_en),
   .status_word(status_word), .control_word(control_word));
`default_nettype wire

// ---- testbench/gcs_plc.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcs_plc (
   input  wire logic       clk,
   input  wire logic [7:0] area_rdata,
   output logic      [9:0] area_addr,
   output logic            area_wr,
   output logic      [7:0] area_wdata,
   output logic            area_rd
);
   initial begin
      area_addr = 10'h000;
      area_wr = 1'b0;
      area_wdata = 8'h00;
      area_rd = 1'b0;
   end
   // word write, high byte first; valid, send and confirm bits come from the caller
   task automatic wr_word(input logic [9:0] a, input logic [15:0] v);
      @(posedge clk);
      area_addr <= a;
      area_wdata <= v[15:8];
      area_wr <= 1'b1;
      @(posedge clk);
      area_addr <= a + 10'h001;
      area_wdata <= v[7:0];
      @(posedge clk);
      area_wr <= 1'b0;
      area_wdata <= ~v[7:0];
   endtask
   // status is read without blocking on its valid bit
   task automatic rd_word(input logic [9:0] a, output logic [15:0] v);
      @(posedge clk);
      area_addr <= a;
      area_rd <= 1'b1;
      @(posedge clk);
      area_addr <= a + 10'h001;
      #1;
      v[15:8] = area_rdata;
      @(posedge clk);
      area_rd <= 1'b0;
      #1;
      v[7:0] = area_rdata;
   endtask
endmodule // gcs_plc
`default_nettype wire

// ---- testbench/tb_gateway_control_status_words.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_gateway_control_status_words;
   logic        clk = 1'b0, rst = 1'b1;
   logic [1:0]  csw_mode = 2'h0;
   logic        generic_mode = 1'b0, fieldbus_online = 1'b0, all_trans_done = 1'b0;
   logic        errors_cleared = 1'b0, report_req = 1'b0;
   logic [4:0]  evt_strobe = 5'h00;
   logic [7:0]  evt_arg = 8'h00, area_rdata, area_wdata, ctrl_data;
   logic [9:0]  area_addr;
   logic        area_wr, area_rd, area_hit, report_busy, exchange_en, ctrl_valid, ctrl_report_new;
   logic [15:0] status_word, control_word, d;
   int          n_errors = 0, checks = 0;
   always #50 clk = ~clk;
   gcs_words dut (.clk(clk), .rst(rst), .csw_mode(csw_mode), .generic_mode(generic_mode),
      .fieldbus_online(fieldbus_online), .area_addr(area_addr), .area_wr(area_wr),
      .area_wdata(area_wdata), .area_rd(area_rd), .area_rdata(area_rdata), .area_hit(area_hit),
      .all_trans_done(all_trans_done), .evt_strobe(evt_strobe), .evt_arg(evt_arg),
      .errors_cleared(errors_cleared), .report_req(report_req), .report_busy(report_busy),
      .exchange_en(exchange_en), .ctrl_valid(ctrl_valid), .ctrl_report_new(ctrl_report_new),
      .ctrl_data(ctrl_data), .status_word(status_word), .control_word(control_word));
   gcs_plc plc (.clk(clk), .area_rdata(area_rdata), .area_addr(area_addr), .area_wr(area_wr),
      .area_wdata(area_wdata), .area_rd(area_rd));
   task automatic final_report();
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_tog(input logic t);
      @(negedge clk);
      for (int k = 0; k < 40 && status_word[15] !== t; k++)
         @(negedge clk);
      `CHK(status_word[15], t)
   endtask
   task automatic t_disabled();
      do_reset();
      plc.wr_word(10'h200, 16'hE0A5);
      plc.rd_word(10'h200, d);
      `CHK({d, control_word}, 32'h00000000)
   endtask
   task automatic t_lock();
      @(posedge clk);
      csw_mode <= 2'h1;
      fieldbus_online <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(exchange_en, 1'b0)
      plc.wr_word(10'h000, 16'hFFFF);
      plc.rd_word(10'h000, d);
      `CHK(d, 16'h0000)
      plc.wr_word(10'h200, 16'h205A);
      plc.rd_word(10'h201, d);
      `CHK(d[15:8], 8'h5A)
      `CHK({exchange_en, ctrl_valid, control_word, ctrl_data}, 26'h3205A5A)
      @(posedge clk);
      fieldbus_online <= 1'b0;
      plc.wr_word(10'h200, 16'h0000);
      csw_mode <= 2'h2;
      fieldbus_online <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(exchange_en, 1'b1)
   endtask
   task automatic t_reports(input logic gm);
      logic [7:0] a;
      do_reset();
      csw_mode <= 2'h2;
      generic_mode <= gm;
      fieldbus_online <= 1'b1;
      repeat (6) @(posedge clk);
      all_trans_done <= 1'b1;
      repeat (2) @(posedge clk);
      all_trans_done <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         evt_arg <= 8'h40 + 8'(i);
         evt_strobe <= 5'h01 << i;
         @(posedge clk);
         evt_strobe <= 5'h00;
         wait_tog(~i[0]);
         a = (gm && i != 0 && i != 2) ? 8'h00 : 8'h40 + 8'(i);
         plc.rd_word(10'h000, d);
         `CHK(d, {~i[0], 1'b0, ~gm, 5'(i), a})
         plc.wr_word(10'h200, {~i[0], 15'h0000});
      end
      plc.wr_word(10'h200, 16'hC0A5);
      @(negedge clk);
      `CHK({ctrl_report_new, status_word[14], ctrl_data}, 10'h3A5)
      @(negedge clk);
      `CHK(ctrl_report_new, 1'b0)
      @(posedge clk);
      errors_cleared <= 1'b1;
      report_req <= 1'b1;
      @(posedge clk);
      report_req <= 1'b0;
      errors_cleared <= 1'b0;
      wait_tog(1'b0);
      `CHK(status_word, {2'h1, ~gm, 5'h1F, 8'h00})
      @(posedge clk);
      evt_strobe <= 5'h08;
      @(posedge clk);
      evt_strobe <= 5'h00;
      repeat (3) @(negedge clk);
      `CHK({report_busy, status_word[15]}, 2'h2)
   endtask
   initial begin
      t_disabled();
      t_lock();
      t_reports(1'b1);
      t_reports(1'b0);
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end
endmodule // tb_gateway_control_status_words
`default_nettype wire
